// file: ebt_pkg.sv
package ebt_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00; // Control fields
    localparam logic [7:0] OFS_PERIOD = 8'h04; // Reload period
    localparam logic [7:0] OFS_CMP    = 8'h08; // Compare value
    localparam logic [7:0] OFS_COUNT  = 8'h0c; // Live count, read only
    localparam logic [7:0] OFS_DIV    = 8'h10; // System clock divisor
    localparam logic [7:0] OFS_STAT   = 8'h14; // Sticky events, read only
    localparam logic [7:0] OFS_ICLR   = 8'h18; // Event clear, write only
    localparam logic [7:0] OFS_IEN    = 8'h1c; // Interrupt enable

    // ------------------------------------------------------------
    // Widths, field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_W     = 12;    // Control bits in use
    localparam int         STAT_W     = 2;     // Status bits in use
    localparam int         STAT_TIMER = 0;     // Selected timer event
    localparam int         STAT_CAP   = 1;     // Capture event
    localparam logic [7:0] RST_PERIOD = 8'hff; // Period after reset
    localparam logic [7:0] RST_CMP    = 8'h00; // Compare after reset
    localparam logic [7:0] RST_DIV    = 8'h00; // Divide by one

    // Control register, bit 0 is enable
    typedef struct packed {
        logic [2:0] cmp_route;   // 0 off, n routes to row n-1
        logic [2:0] tc_route;    // 0 off, n routes to row n-1
        logic       pulse_width; // 0 full input clock, 1 one cycle
        logic       clk_src;     // 0 divided system clock, 1 low speed
        logic       clk_sync;    // Resync low speed tick
        logic       irq_src;     // 0 terminal count, 1 compare
        logic       cmp_mode;    // 0 less than, 1 less or equal
        logic       enable;      // Timer running
    } ebt_ctrl_type;

    localparam ebt_ctrl_type RST_CTRL = '0;

endpackage

// file: ebt_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with rising edge detect on the safe side
module ebt_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic meta;   // First stage, read only by second
        logic stable; // Second stage
        logic prev;   // Previous stable value
    } ebt_sync_type;

    ebt_sync_type s;
    ebt_sync_type next_s;

    // Shift chain
    always_comb begin
        next_s        = s;
        next_s.meta   = async_in;
        next_s.stable = s.meta;
        next_s.prev   = s.stable;
    end

    // Register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.stable;
    assign rise  = s.stable & ~s.prev;

endmodule

// file: ebt_prescale.sv
`timescale 1ns/1ps
// Divides the system clock by div+1, giving a one-cycle tick
module ebt_prescale #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] div,
    output logic              tick
);

    initial begin
        if (W < 1 || W > 16) begin
            $error("ebt_prescale: W out of range");
        end
    end

    typedef struct packed {
        logic [W-1:0] cnt; // Cycles since last tick
    } ebt_pre_type;

    ebt_pre_type s;
    ebt_pre_type next_s;

    // Wrap at the divisor
    always_comb begin
        next_s = s;
        if (s.cnt >= div) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = (s.cnt >= div);

endmodule

// file: ebt_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Eight-bit count advanced by selected input clock
// [RULE2] Period register accepts any value 0..255
// [RULE3] Reload at zero and on enable
// [RULE4] Capture rising edge copies count to compare
// [RULE5] Capture source must not stay high
// [RULE6] Compare event at programmed compare value
// [RULE7] Compare test less-than or less-or-equal
// [RULE8] Terminal count output off or to row
// [RULE9] Compare routing never affects interrupts
// [RULE10] Compare always fed to next block
// [RULE11] Low speed clock selectable as count source
// [RULE12] Interrupt source terminal count or compare
// [RULE13] Optional resync of input clock tick
// [RULE14] Decrement per tick, terminal pulse at zero
module ebt_timer #(
    parameter int ROWS = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic             capture_in,
    input  wire logic             low_speed_clock_source,
    output logic [ROWS-1:0]       row_out,
    output logic                  compare_to_next,
    output logic                  irq
);

    initial begin
        if (ROWS < 1 || ROWS > 7) begin
            $error("ebt_timer: ROWS must be 1 to 7");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                      wr_pend;  // Write data phase due
        logic [7:0]                waddr;    // Offset of that write
        logic [31:0]               rdata;    // Read data for bus
        ebt_pkg::ebt_ctrl_type     ctrl;     // Control fields
        logic [7:0]                period;   // Reload value
        logic [7:0]                cmpv;     // Compare value
        logic [7:0]                count;    // Live count
        logic [7:0]                div;      // Prescale divisor
        logic [ebt_pkg::STAT_W-1:0] stat;    // Sticky events
        logic [ebt_pkg::STAT_W-1:0] ien;     // Interrupt enables
        logic                      en_d;     // Enable last cycle
        logic                      cmp_lvl;  // Compare true
        logic                      lsc_d;    // Resynced slow tick
        logic                      tc_out;   // Terminal count level
        logic [ROWS-1:0]           rows;     // Routed row outputs
    } ebt_state_type;

    ebt_state_type s;
    ebt_state_type next_s;

    logic pre_tick;   // Divided system clock tick
    logic lsc_rise;   // Low speed clock rising edge
    logic cap_rise;   // Capture rising edge
    logic tick;       // Selected count tick
    logic tc_ev;      // Terminal count this cycle
    logic cmp_now;    // Compare test result
    logic cmp_ev;     // Compare became true
    logic take;       // Bus address phase accepted

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare test, mode selects strict or inclusive
    function automatic logic cmp_test(input logic [7:0] c,
                                      input logic [7:0] v,
                                      input logic       le);
        cmp_test = le ? (c <= v) : (c < v); // [RULE7]
    endfunction

    // True when a route field selects row r
    function automatic logic route_hit(input logic [2:0] route,
                                       input int         r);
        route_hit = (route == 3'(r + 1));
    endfunction

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    ebt_sync u_cap_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (capture_in),
        .level    (),
        .rise     (cap_rise)
    );

    ebt_sync u_lsc_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (low_speed_clock_source),
        .level    (),
        .rise     (lsc_rise)
    );

    ebt_prescale #(
        .W (8)
    ) u_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .div      (s.div),
        .tick     (pre_tick)
    );

    // ------------------------------------------------------------
    // Tick selection and events
    // ------------------------------------------------------------
    always_comb begin
        // Low speed source, optionally one more resync stage
        if (s.ctrl.clk_src) begin
            tick = s.ctrl.clk_sync ? s.lsc_d : lsc_rise; // [RULE11] [RULE13]
        end else begin
            tick = pre_tick; // [RULE1]
        end
        tick    = tick & s.ctrl.enable & s.en_d;
        tc_ev   = tick & (s.count == 8'h00); // [RULE14]
        cmp_now = s.ctrl.enable
                & cmp_test(s.count, s.cmpv, s.ctrl.cmp_mode); // [RULE6]
        cmp_ev  = cmp_now & ~s.cmp_lvl;
        take    = hsel & hready & htrans[1];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;

        // Bus address phase: latch write, prepare read data
        next_s.wr_pend = take & hwrite;
        if (take) begin
            next_s.waddr = haddr[7:0];
        end
        if (take && !hwrite) begin
            case (haddr[7:0])
                ebt_pkg::OFS_CTRL: begin
                    next_s.rdata = 32'(s.ctrl);
                end
                ebt_pkg::OFS_PERIOD: begin
                    next_s.rdata = 32'(s.period);
                end
                ebt_pkg::OFS_CMP: begin
                    next_s.rdata = 32'(s.cmpv);
                end
                ebt_pkg::OFS_COUNT: begin
                    next_s.rdata = 32'(s.count);
                end
                ebt_pkg::OFS_DIV: begin
                    next_s.rdata = 32'(s.div);
                end
                ebt_pkg::OFS_STAT: begin
                    next_s.rdata = 32'(s.stat);
                end
                ebt_pkg::OFS_IEN: begin
                    next_s.rdata = 32'(s.ien);
                end
                default: begin
                    // Unmapped and write-only read as zero
                    next_s.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Bus data phase: store write data
        if (s.wr_pend) begin
            case (s.waddr)
                ebt_pkg::OFS_CTRL: begin
                    next_s.ctrl = hwdata[ebt_pkg::CTRL_W-1:0];
                end
                ebt_pkg::OFS_PERIOD: begin
                    next_s.period = hwdata[7:0]; // [RULE2]
                end
                ebt_pkg::OFS_CMP: begin
                    next_s.cmpv = hwdata[7:0];
                end
                ebt_pkg::OFS_DIV: begin
                    next_s.div = hwdata[7:0];
                end
                ebt_pkg::OFS_ICLR: begin
                    next_s.stat = s.stat & ~hwdata[ebt_pkg::STAT_W-1:0];
                end
                ebt_pkg::OFS_IEN: begin
                    next_s.ien = hwdata[ebt_pkg::STAT_W-1:0];
                end
                default: begin
                    // Read-only and unmapped writes are dropped
                end
            endcase
        end

        // Counter: reload on enable or at zero, else count down on tick
        next_s.en_d  = s.ctrl.enable;
        next_s.lsc_d = lsc_rise;
        if (s.ctrl.enable && !s.en_d) begin
            next_s.count = s.period; // [RULE3]
        end else if (tc_ev) begin
            next_s.count = s.period; // [RULE3]
        end else if (tick) begin
            next_s.count = s.count - 8'h01; // [RULE1] [RULE14]
        end

        // Capture wins over a software compare write
        if (cap_rise) begin
            next_s.cmpv = s.count; // [RULE4]
        end

        // Sticky events; a set beats a clear in the same cycle
        if (s.ctrl.irq_src ? cmp_ev : tc_ev) begin
            next_s.stat[ebt_pkg::STAT_TIMER] = 1'b1; // [RULE12] [RULE9]
        end
        if (cap_rise) begin
            next_s.stat[ebt_pkg::STAT_CAP] = 1'b1;
        end

        // Output levels
        next_s.cmp_lvl = cmp_now;
        if (s.ctrl.pulse_width) begin
            next_s.tc_out = tc_ev; // [RULE14]
        end else begin
            next_s.tc_out = s.ctrl.enable & (s.count == 8'h00);
        end
        for (int r = 0; r < ROWS; r++) begin
            next_s.rows[r] = (route_hit(s.ctrl.tc_route, r) & s.tc_out)
                | (route_hit(s.ctrl.cmp_route, r) & s.cmp_lvl); // [RULE8]
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s        <= '0;
            s.ctrl   <= ebt_pkg::RST_CTRL;
            s.period <= ebt_pkg::RST_PERIOD;
            s.cmpv   <= ebt_pkg::RST_CMP;
            s.div    <= ebt_pkg::RST_DIV;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = s.rdata;
    assign row_out         = s.rows;
    assign compare_to_next = s.cmp_lvl; // [RULE10]
    assign irq             = |(s.stat & s.ien);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_count_dec;
        @(posedge core_clk) disable iff (rst)
        (tick && s.count != 8'h00 && s.ctrl.enable)
            |=> (s.count == $past(s.count) - 8'h01);
    endproperty
    a_count_dec: assert property (p_count_dec) // [RULE14]
        else $error("count did not decrement on tick");

    property p_reload_zero;
        @(posedge core_clk) disable iff (rst)
        tc_ev |=> (s.count == $past(s.period));
    endproperty
    a_reload_zero: assert property (p_reload_zero) // [RULE3]
        else $error("count not reloaded at zero");

    property p_reload_enable;
        @(posedge core_clk) disable iff (rst)
        (s.ctrl.enable && !s.en_d) |=> (s.count == $past(s.period));
    endproperty
    a_reload_enable: assert property (p_reload_enable) // [RULE3]
        else $error("count not reloaded on enable");

    property p_capture;
        @(posedge core_clk) disable iff (rst)
        cap_rise |=> (s.cmpv == $past(s.count));
    endproperty
    a_capture: assert property (p_capture) // [RULE4]
        else $error("capture did not copy count");

    property p_cmp_lt;
        @(posedge core_clk) disable iff (rst)
        (s.ctrl.enable && !s.ctrl.cmp_mode && s.count < s.cmpv)
            |=> compare_to_next;
    endproperty
    a_cmp_lt: assert property (p_cmp_lt) // [RULE6]
        else $error("compare missing below value");

    property p_cmp_eq;
        @(posedge core_clk) disable iff (rst)
        (s.ctrl.enable && s.count == s.cmpv)
            |=> (compare_to_next == $past(s.ctrl.cmp_mode));
    endproperty
    a_cmp_eq: assert property (p_cmp_eq) // [RULE7]
        else $error("compare mode wrong at equality");

    property p_irq_tc;
        @(posedge core_clk) disable iff (rst)
        (tc_ev && !s.ctrl.irq_src) |=> s.stat[ebt_pkg::STAT_TIMER];
    endproperty
    a_irq_tc: assert property (p_irq_tc) // [RULE12]
        else $error("terminal count did not set status");

    property p_route_off;
        @(posedge core_clk) disable iff (rst)
        (s.ctrl.tc_route == 3'h0 && s.ctrl.cmp_route == 3'h0)
            |=> (row_out == '0);
    endproperty
    a_route_off: assert property (p_route_off) // [RULE8]
        else $error("row output driven while unrouted");

    property p_period_store;
        @(posedge core_clk) disable iff (rst)
        (s.wr_pend && s.waddr == ebt_pkg::OFS_PERIOD)
            |=> (s.period == $past(hwdata[7:0]));
    endproperty
    a_period_store: assert property (p_period_store) // [RULE2]
        else $error("period write not stored");

endmodule

// file: eight_bit_down_timer_bench.sv
`timescale 1ns/1ps
module eight_bit_down_timer_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        core_clk;   // 20 MHz system clock
    logic        rst;        // Synchronous reset
    logic        hsel;       // Bus select
    logic [31:0] haddr;      // Bus address
    logic [1:0]  htrans;     // Transfer type
    logic        hwrite;     // Write strobe
    logic [2:0]  hsize;      // Always a word
    logic [31:0] hwdata;     // Write data
    logic        hready;     // Bus ready, from the one slave
    logic        hreadyout;  // Slave ready
    logic        hresp;      // Slave response
    logic [31:0] hrdata;     // Read data
    logic        cap_pin;    // Capture pin
    logic        slow_pin;   // Low speed count pin
    logic [3:0]  row_out;    // Routed row outputs
    logic        cmp_next;   // Compare level to next block
    logic        irq;        // Interrupt level
    int          error_cnt;  // Mismatches
    int          checks_done; // Comparisons made
    int          cyc_cnt;    // Free running cycle count
    logic [31:0] rs;         // Random state

    assign hready = hreadyout;

    ebt_timer #(.ROWS(4)) dut_u (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .capture_in(cap_pin),
        .low_speed_clock_source(slow_pin), .row_out(row_out),
        .compare_to_next(cmp_next), .irq(irq));

    // ------------------------------------------------------------
    // Clock, cycle count and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc_cnt <= cyc_cnt + 1;

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Next random value
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Control word: compare route, tc route, low six bits
    function automatic logic [31:0] ctl(input logic [2:0] cr,
                                        input logic [2:0] tc,
                                        input logic [5:0] lo);
        return {20'h0, cr, tc, lo};
    endfunction

    // Expected compare test result
    function automatic logic exp_cmp(input logic [7:0] c,
                                     input logic [7:0] v,
                                     input logic m);
        return m ? (c <= v) : (c < v);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Waits for hready high at an edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 16) begin
                error_cnt++;
                finish_test();
            end
            @(posedge core_clk);
        end
    endtask

    // One single word transfer, address then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        // Slave must always answer OKAY
        chk({31'h0, hresp}, 32'h0, "response");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string s);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e, s);
    endtask

    // One slow clock period, settled before return
    task automatic tick();
        slow_pin <= 1'b1;
        cyc(4);
        slow_pin <= 1'b0;
        cyc(4);
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  p;
        logic [7:0]  v;
        logic [7:0]  d;
        logic [31:0] x;
        int          n;
        int          t0;
        int          dec;
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = '0;
        cap_pin = 1'b0; slow_pin = 1'b0;
        error_cnt = 0; checks_done = 0; cyc_cnt = 0;
        rs = 32'h5071d5fe;
        cyc(12);
        rst <= 1'b0;
        cyc(1);
        // Reset values, unmapped place reads zero
        rdc(ebt_pkg::OFS_CTRL, 32'h0, "ctrl reset");
        rdc(ebt_pkg::OFS_PERIOD, 32'hff, "period reset");
        rdc(ebt_pkg::OFS_CMP, 32'h0, "compare reset");
        rdc(ebt_pkg::OFS_STAT, 32'h0, "status reset");
        rdc(8'h20, 32'h0, "unmapped");
        // Period takes boundary and random values
        for (int i = 0; i < 5; i++) begin
            rs = lfsr(rs);
            p = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rs[7:0];
            wr(ebt_pkg::OFS_PERIOD, {24'h0, p});
            rdc(ebt_pkg::OFS_PERIOD, {24'h0, p}, "period");
        end
        // Slow clock counting, unsynced then synced
        wr(ebt_pkg::OFS_IEN, 32'h3);
        for (int s = 0; s < 2; s++) begin
            rs = lfsr(rs);
            p = {5'h0, rs[2:0]} + 8'd2;
            n = int'(rs[15:8]) % int'(p) + 1;
            wr(ebt_pkg::OFS_CTRL, 32'h0);
            wr(ebt_pkg::OFS_PERIOD, {24'h0, p});
            wr(ebt_pkg::OFS_ICLR, 32'h3);
            wr(ebt_pkg::OFS_CTRL, ctl(0, 0, {2'b01, s[0], 3'b001}));
            cyc(1); // Count loads one edge after enable lands
            rdc(ebt_pkg::OFS_COUNT, {24'h0, p}, "enable load");
            repeat (n) tick();
            rdc(ebt_pkg::OFS_COUNT, {24'h0, p - 8'(n)}, "dec");
            rdc(ebt_pkg::OFS_STAT, 32'h0, "no tc yet");
            chk({31'h0, irq}, 32'h0, "irq idle");
            repeat (int'(p) - n + 1) tick();
            rdc(ebt_pkg::OFS_COUNT, {24'h0, p}, "zero load");
            rdc(ebt_pkg::OFS_STAT, 32'h1, "tc event");
            chk({31'h0, irq}, 32'h1, "irq on tc");
            wr(ebt_pkg::OFS_ICLR, 32'h1);
            rdc(ebt_pkg::OFS_STAT, 32'h0, "cleared");
            chk({31'h0, irq}, 32'h0, "irq cleared");
            wr(ebt_pkg::OFS_COUNT, 32'h5a);
            rdc(ebt_pkg::OFS_COUNT, {24'h0, p}, "count read only");
            wr(ebt_pkg::OFS_CTRL, 32'h0);
            tick();
            p = p + 8'd5;
            wr(ebt_pkg::OFS_PERIOD, {24'h0, p});
            wr(ebt_pkg::OFS_CTRL, ctl(0, 0, {2'b01, s[0], 3'b001}));
            cyc(1); // Count loads one edge after enable lands
            rdc(ebt_pkg::OFS_COUNT, {24'h0, p}, "re-enable");
        end
        // Compare test in both modes around the held count
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 3; k++) begin
                rs = lfsr(rs);
                v = p - 8'd1 + 8'(k);
                wr(ebt_pkg::OFS_CTRL,
                   ctl(3'(rs[3:0] % 5), 0, {4'b0100, m[0], 1'b1}));
                wr(ebt_pkg::OFS_CMP, {24'h0, v});
                cyc(3);
                chk({31'h0, cmp_next}, {31'h0, exp_cmp(p, v, m[0])},
                    "compare level");
            end
        end
        // Compare event raises the interrupt with routing off
        wr(ebt_pkg::OFS_CTRL, ctl(0, 0, 6'b010101));
        wr(ebt_pkg::OFS_CMP, {24'h0, p});
        cyc(3);
        wr(ebt_pkg::OFS_ICLR, 32'h3);
        rdc(ebt_pkg::OFS_STAT, 32'h0, "no compare event");
        wr(ebt_pkg::OFS_CMP, {24'h0, p + 8'd1});
        cyc(3);
        rdc(ebt_pkg::OFS_STAT, 32'h1, "compare event");
        chk({31'h0, irq}, 32'h1, "irq on compare");
        // Row routing of terminal count and compare levels
        wr(ebt_pkg::OFS_CTRL, 32'h0);
        wr(ebt_pkg::OFS_PERIOD, 32'h0);
        wr(ebt_pkg::OFS_CMP, 32'h0);
        for (int r = 1; r <= 4; r++) begin
            wr(ebt_pkg::OFS_CTRL, ctl(0, 3'(r), 6'b010001));
            cyc(4); // Reload, level and row stage after enable
            chk({28'h0, row_out}, 32'h1 << (r - 1), "tc row");
            wr(ebt_pkg::OFS_CTRL, ctl(3'(r), 0, 6'b010011));
            cyc(3);
            chk({28'h0, row_out}, 32'h1 << (r - 1), "cmp row");
        end
        wr(ebt_pkg::OFS_CTRL, ctl(0, 0, 6'b010011));
        cyc(3);
        chk({28'h0, row_out}, 32'h0, "routes off");
        chk({31'h0, cmp_next}, 32'h1, "next block");
        // Pulse mode: count sits at zero but no tick, so no output
        wr(ebt_pkg::OFS_CTRL, ctl(0, 3'd1, 6'b110001));
        cyc(4);
        chk({28'h0, row_out}, 32'h0, "tc pulse idle");
        // Capture copies the count into compare
        rs = lfsr(rs);
        p = rs[7:0] | 8'h10;
        n = int'(rs[10:8]);
        wr(ebt_pkg::OFS_CTRL, 32'h0);
        wr(ebt_pkg::OFS_PERIOD, {24'h0, p});
        wr(ebt_pkg::OFS_CTRL, ctl(0, 0, 6'b010001));
        repeat (n) tick();
        wr(ebt_pkg::OFS_ICLR, 32'h3);
        cap_pin <= 1'b1;
        cyc(4);
        cap_pin <= 1'b0;
        cyc(4);
        rdc(ebt_pkg::OFS_CMP, {24'h0, p - 8'(n)}, "captured");
        rdc(ebt_pkg::OFS_STAT, 32'h2, "capture event");
        // Divided system clock drives the count
        rs = lfsr(rs);
        d = 8'd8 + {5'h0, rs[2:0]};
        wr(ebt_pkg::OFS_CTRL, 32'h0);
        wr(ebt_pkg::OFS_PERIOD, 32'hff);
        wr(ebt_pkg::OFS_DIV, {24'h0, d});
        wr(ebt_pkg::OFS_CTRL, 32'h1);
        t0 = cyc_cnt;
        cyc(100);
        bus(1'b0, ebt_pkg::OFS_COUNT, 32'h0, x);
        dec = (cyc_cnt - t0) / (int'(d) + 1);
        chk({31'h0, (int'(x) >= 252 - dec) && (int'(x) <= 258 - dec)},
            32'h1, "divided rate");
        finish_test();
    end
endmodule
